// ==== design/dgsb_status_bytes.sv ====
// The implementer's own choices: the address map and register access over APB.
`default_nettype none

module dgsb_status_bytes (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire dgsb_pkg::dgsb_sw_t  sw_pins,
  input  wire dgsb_pkg::dgsb_evt_t events,
  input  wire logic                status_query,
  output logic      [23:0]         reply_bytes,
  output logic                     reply_valid,
  output logic                     fault_lamp,
  output logic                     error_log_enable
);
  import dgsb_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  dgsb_state_t st_r;
  dgsb_state_t st_nxt;

  dgsb_sw_t               sw_q;
  logic [DGSB_NERR-1:0]   err_q;
  logic [DGSB_NERR-1:0]   err_set;
  logic [DGSB_NERR-1:0]   err_clr;

  logic                   acc;
  logic                   commit;
  logic                   hit;
  logic                   wr_ctrl;
  logic                   wr_err;
  logic [31:0]            rd_val;
  logic [7:0]             req_byte;
  logic [7:0]             mode_byte;
  logic [7:0]             err_byte;
  logic                   lamp_cause;

  // ==========================================================
  // Panel switches cross into the clock domain
  // ==========================================================
  dgsb_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (sw_pins),
    .q       (sw_q)
  );

  // ==========================================================
  // Error class flags
  // ==========================================================
  // Every error input is a one-cycle pulse from logic on pclk
  assign err_set[DGSB_E_DE] = events.internal_fault;
  assign err_set[DGSB_E_RE] = events.frame_err | events.checksum_err;
  assign err_set[DGSB_E_PE] = events.protocol_err;
  assign err_set[DGSB_E_DF] = events.init_test_fail;
  // Only a write-type command on a protected drive counts
  assign err_set[DGSB_E_WE] = (events.track_write_cmd | events.format_cmd)
                              & sw_q.write_lock_switch;

  // Software clears with write-one; a same-cycle event still wins
  assign err_clr = wr_err ? pwdata[DGSB_ERR_LSB +: DGSB_NERR] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < DGSB_NERR; gi++) begin : g_err
      dgsb_sticky u_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (err_set[gi]),
        .clr     (err_clr[gi]),
        .flag    (err_q[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Generic status bytes
  // ==========================================================
  assign req_byte = {
    ~st_r.ctrl.online,
    st_r.ctrl.readjust_request,
    st_r.ctrl.diag_load_request,
    st_r.ctrl.spindle_ready,
    st_r.ctrl.log_info_pending,
    sw_q.port_b_select,
    sw_q.port_switch_in,
    sw_q.go_stop_switch_in
  };

  assign mode_byte = {
    st_r.ctrl.log_disable_field,
    1'b0,
    sw_q.write_lock_switch,
    st_r.ctrl.controller_disabled_flag,
    st_r.ctrl.layout_write_allowed,
    st_r.ctrl.diag_area_access,
    DGSB_SECTOR_512
  };

  // Unused low positions stay zero
  assign err_byte = {err_q, 3'h0};

  // Transmission and protocol errors are link trouble, not a drive fault
  assign lamp_cause = st_r.ctrl.controller_disabled_flag
                    | err_q[DGSB_E_DE]
                    | err_q[DGSB_E_DF]
                    | err_q[DGSB_E_WE];

  // ==========================================================
  // APB slave decode
  // ==========================================================
  // One wait state lets read data leave a flip-flop
  assign acc     = psel & penable;
  assign commit  = acc & st_r.pready;
  assign hit     = (paddr == DGSB_OFF_CTRL)
                 | (paddr == DGSB_OFF_ERR)
                 | (paddr == DGSB_OFF_STAT);
  assign wr_ctrl = commit & pwrite & (paddr == DGSB_OFF_CTRL);
  assign wr_err  = commit & pwrite & (paddr == DGSB_OFF_ERR);

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      DGSB_OFF_CTRL: rd_val[DGSB_CTRL_W-1:0] = st_r.ctrl;
      DGSB_OFF_ERR:  rd_val[7:0] = err_byte;
      DGSB_OFF_STAT: rd_val[23:0] = {req_byte, mode_byte, err_byte};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_nxt             = st_r;
    st_nxt.pready      = 1'b0;
    st_nxt.pslverr     = 1'b0;
    st_nxt.reply_valid = 1'b0;

    if (acc && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = ~hit;
      st_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_val;
    end

    if (wr_ctrl) begin
      st_nxt.ctrl = dgsb_ctrl_t'(pwdata[DGSB_CTRL_W-1:0]);
    end

    // Snapshot on query; the link framer sends it at bytes 4..6
    if (status_query) begin
      st_nxt.reply       = {req_byte, mode_byte, err_byte};
      st_nxt.reply_valid = 1'b1;
    end

    st_nxt.fault_lamp = lamp_cause;
    // Only code 10 switches logging off; other codes keep it on
    st_nxt.log_en = (st_r.ctrl.log_disable_field != DGSB_LOG_OFF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= DGSB_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign reply_bytes      = st_r.reply;
  assign reply_valid      = st_r.reply_valid;
  assign fault_lamp       = st_r.fault_lamp;
  assign error_log_enable = st_r.log_en;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reply_follows: assert property (status_query |=> reply_valid)
    else $error("query not answered next cycle");

  a_reply_order: assert property (status_query |=>
      reply_bytes[23:16] == $past(req_byte) && reply_bytes[7:0] == $past(err_byte))
    else $error("status bytes out of place");

  a_not_attached: assert property (reply_valid |->
      reply_bytes[23] == !$past(st_r.ctrl.online))
    else $error("not-attached flag wrong");

  a_log_disable: assert property (st_r.ctrl.log_disable_field == DGSB_LOG_OFF
      |=> !error_log_enable)
    else $error("logging not disabled by code 10");

  a_lamp_dd: assert property (st_r.ctrl.controller_disabled_flag |=> fault_lamp)
    else $error("lamp dark with drive disabled");

  a_sector_zero: assert property (reply_valid |-> reply_bytes[8] == 1'b0)
    else $error("sector size flag not zero");

  a_de_lamp: assert property (events.internal_fault |=> err_q[DGSB_E_DE] ##1 fault_lamp)
    else $error("internal fault not flagged or lit");

  a_re_dark: assert property (
      (err_q == (DGSB_NERR)'(1 << DGSB_E_RE) || err_q == (DGSB_NERR)'(1 << DGSB_E_PE))
      && !st_r.ctrl.controller_disabled_flag |=> !fault_lamp)
    else $error("lamp lit by link or protocol error");

  a_we_set: assert property (
      (events.track_write_cmd || events.format_cmd) && sw_q.write_lock_switch
      |=> err_q[DGSB_E_WE])
    else $error("write lock violation missed");

  a_unused_zero: assert property (reply_valid |->
      reply_bytes[13] == 1'b0 && reply_bytes[2:0] == 3'h0)
    else $error("unused status bits not zero");

  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not acknowledged");

  // ==========================================================
  // Status byte fields
  // ==========================================================
  // One check per flag, except the five error flags checked as one field, so a swapped pair points at its own rule
  a_readjust_bit: assert property (reply_valid |->
      reply_bytes[22] == $past(st_r.ctrl.readjust_request))
    else $error("readjust request flag wrong");

  a_diag_load_bit: assert property (reply_valid |->
      reply_bytes[21] == $past(st_r.ctrl.diag_load_request))
    else $error("diagnostic load request flag wrong");

  a_spindle_bit: assert property (reply_valid |->
      reply_bytes[20] == $past(st_r.ctrl.spindle_ready))
    else $error("spindle ready flag wrong");

  a_log_pend_bit: assert property (reply_valid |->
      reply_bytes[19] == $past(st_r.ctrl.log_info_pending))
    else $error("log pending flag wrong");

  a_port_b_bit: assert property (reply_valid |->
      reply_bytes[18] == $past(sw_q.port_b_select))
    else $error("port flag wrong");

  a_port_sw_bit: assert property (reply_valid |->
      reply_bytes[17] == $past(sw_q.port_switch_in))
    else $error("port switch flag wrong");

  a_go_stop_bit: assert property (reply_valid |->
      reply_bytes[16] == $past(sw_q.go_stop_switch_in))
    else $error("go-stop flag wrong");

  a_log_field: assert property (reply_valid |->
      reply_bytes[15:14] == $past(st_r.ctrl.log_disable_field))
    else $error("log disable field wrong");

  a_write_lock_bit: assert property (reply_valid |->
      reply_bytes[12] == $past(sw_q.write_lock_switch))
    else $error("write lock flag wrong");

  a_disabled_bit: assert property (reply_valid |->
      reply_bytes[11] == $past(st_r.ctrl.controller_disabled_flag))
    else $error("disabled flag wrong");

  a_format_bit: assert property (reply_valid |->
      reply_bytes[10] == $past(st_r.ctrl.layout_write_allowed))
    else $error("format allowed flag wrong");

  a_diag_area_bit: assert property (reply_valid |->
      reply_bytes[9] == $past(st_r.ctrl.diag_area_access))
    else $error("diagnostic area flag wrong");

  a_err_field: assert property (reply_valid |->
      reply_bytes[7:3] == $past(err_q))
    else $error("error byte flags wrong");

  // Logging, error classes and the lamp
  a_log_enabled: assert property (
      st_r.ctrl.log_disable_field != DGSB_LOG_OFF |=> error_log_enable)
    else $error("logging off with a keep-on code");

  a_re_set: assert property (
      events.frame_err || events.checksum_err |=> err_q[DGSB_E_RE])
    else $error("transmission error not flagged");

  a_pe_set: assert property (
      events.protocol_err |=> err_q[DGSB_E_PE])
    else $error("protocol error not flagged");

  a_df_lamp: assert property (
      events.init_test_fail |=> err_q[DGSB_E_DF] ##1 fault_lamp)
    else $error("init failure not flagged or lit");

  a_we_lamp: assert property (
      err_q[DGSB_E_WE] |=> fault_lamp)
    else $error("lamp dark with write lock violation");

  a_we_refused: assert property (
      !err_q[DGSB_E_WE] && !sw_q.write_lock_switch |=> !err_q[DGSB_E_WE])
    else $error("write lock violation without protect");

  c_query: cover property (status_query ##1 reply_valid);
  c_lamp_on: cover property (!fault_lamp ##1 fault_lamp);
  c_err_clear: cover property (wr_err && |err_clr);
  c_set_clr: cover property (|(err_set & err_clr));
  c_log_off: cover property (!error_log_enable);

endmodule : dgsb_status_bytes

`default_nettype wire

// ==== design/dgsb_sticky.sv ====
`default_nettype none

// ==========================================================
// Sticky error flag, set beats clear
// ==========================================================
module dgsb_sticky (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  import dgsb_pkg::*;

  dgsb_flag_t st_r;
  dgsb_flag_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (set) begin
      st_nxt.flag = 1'b1;
    end else if (clr) begin
      st_nxt.flag = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= DGSB_FLAG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_set_wins: assert property (set |=> flag) else $error("flag lost its set");
  a_clr_works: assert property (clr && !set |=> !flag) else $error("flag not cleared");

endmodule : dgsb_sticky

`default_nettype wire

// ==== design/dgsb_sync.sv ====
`default_nettype none

// ==========================================================
// Two-stage synchroniser for the panel switches
// ==========================================================
module dgsb_sync (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire dgsb_pkg::dgsb_sw_t d,
  output var  dgsb_pkg::dgsb_sw_t q
);
  import dgsb_pkg::*;

  dgsb_sync_t st_r;
  dgsb_sync_t st_nxt;

  // Stage one feeds stage two only
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= DGSB_SYNC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : dgsb_sync

`default_nettype wire

// ==== include/dgsb_pkg.sv ====
`default_nettype none

package dgsb_pkg;

  // ==========================================================
  // Register map (byte addresses on APB)
  // ==========================================================
  localparam logic [7:0] DGSB_OFF_CTRL = 8'h00;
  localparam logic [7:0] DGSB_OFF_ERR  = 8'h04;
  localparam logic [7:0] DGSB_OFF_STAT = 8'h08;

  // ==========================================================
  // Field positions and values
  // ==========================================================
  localparam int         DGSB_CTRL_W    = 10;
  localparam int         DGSB_NERR      = 5;
  localparam int         DGSB_ERR_LSB   = 3;
  localparam int         DGSB_E_WE      = 0;
  localparam int         DGSB_E_DF      = 1;
  localparam int         DGSB_E_PE      = 2;
  localparam int         DGSB_E_RE      = 3;
  localparam int         DGSB_E_DE      = 4;
  localparam logic [1:0] DGSB_LOG_OFF   = 2'h2;
  localparam logic       DGSB_SECTOR_512 = 1'h0;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic       diag_area_access;
    logic       layout_write_allowed;
    logic       controller_disabled_flag;
    logic [1:0] log_disable_field;
    logic       log_info_pending;
    logic       spindle_ready;
    logic       diag_load_request;
    logic       readjust_request;
    logic       online;
  } dgsb_ctrl_t;

  typedef struct packed {
    logic port_b_select;
    logic port_switch_in;
    logic go_stop_switch_in;
    logic write_lock_switch;
  } dgsb_sw_t;

  typedef struct packed {
    logic internal_fault;
    logic frame_err;
    logic checksum_err;
    logic protocol_err;
    logic init_test_fail;
    logic track_write_cmd;
    logic format_cmd;
  } dgsb_evt_t;

  typedef struct packed {
    dgsb_sw_t s1;
    dgsb_sw_t s2;
  } dgsb_sync_t;

  typedef struct packed {
    logic flag;
  } dgsb_flag_t;

  typedef struct packed {
    dgsb_ctrl_t  ctrl;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [23:0] reply;
    logic        reply_valid;
    logic        fault_lamp;
    logic        log_en;
  } dgsb_state_t;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam dgsb_ctrl_t  DGSB_CTRL_RST  = '0;
  localparam dgsb_sync_t  DGSB_SYNC_RST  = '0;
  localparam dgsb_flag_t  DGSB_FLAG_RST  = '0;
  localparam dgsb_state_t DGSB_STATE_RST = '{ctrl: DGSB_CTRL_RST, log_en: 1'b1, default: '0};

endpackage : dgsb_pkg

`default_nettype wire

// ==== verification/dgsb_ctlr_model.sv ====
`default_nettype none

// ==========================================================
// Storage controller side: asks for status, takes the reply
// ==========================================================
module dgsb_ctlr_model (
  input  wire logic        pclk,
  input  wire logic [23:0] reply_bytes,
  input  wire logic        reply_valid,
  output logic             status_query
);
  timeunit 1ns;
  timeprecision 1ps;

  initial status_query = 1'b0;

  // The reply is kept even when no error flag is set, so a
  // controller-detected fault can still be logged
  task automatic query(output logic [23:0] b, output int n);
    n = 0;
    @(posedge pclk);
    status_query <= 1'b1;
    @(posedge pclk);
    status_query <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (reply_valid !== 1'b1 && n < 8);
    b = reply_bytes;
  endtask : query
endmodule : dgsb_ctlr_model

`default_nettype wire

// ==== verification/dgsb_status_bytes_tb.sv ====
`default_nettype none

module dgsb_status_bytes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dgsb_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        status_query, reply_valid, fault_lamp, error_log_enable, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [23:0] reply_bytes, b;
  dgsb_sw_t    sw_pins;
  dgsb_evt_t   events;
  logic [9:0]  ctrl_m;
  logic [3:0]  sw_m;
  logic [4:0]  err_m;
  int          err_total, checked, cycles, n;

  dgsb_status_bytes dgsb_status_bytes_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_pins(sw_pins), .events(events), .status_query(status_query),
    .reply_bytes(reply_bytes), .reply_valid(reply_valid), .fault_lamp(fault_lamp),
    .error_log_enable(error_log_enable));

  dgsb_ctlr_model dgsb_ctlr_model_inst (
    .pclk(pclk), .reply_bytes(reply_bytes), .reply_valid(reply_valid),
    .status_query(status_query));

  // ==========================================================
  // Clock, timeout, reporting
  // ==========================================================
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // ==========================================================
  // APB master: request held until pready is seen at a rising edge
  // ==========================================================
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // A missing pready is caught by the cycle ceiling
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ==========================================================
  // Expected bytes from the model state
  // ==========================================================
  function automatic logic [23:0] expb();
    return {~ctrl_m[0], ctrl_m[1], ctrl_m[2], ctrl_m[3], ctrl_m[4], sw_m[3:1],
            ctrl_m[6:5], 1'b0, sw_m[0], ctrl_m[7], ctrl_m[8], ctrl_m[9], 1'b0,
            err_m, 3'h0};
  endfunction : expb

  function automatic logic [4:0] evt_err(input int i, input logic wl);
    case (i)
      6:       return 5'h10;
      5, 4:    return 5'h08;
      3:       return 5'h04;
      2:       return 5'h02;
      default: return wl ? 5'h01 : 5'h00;
    endcase
  endfunction : evt_err

  task automatic query_chk();
    dgsb_ctlr_model_inst.query(b, n);
    chk(32'(n), 32'h1);
    chk({8'h0, b}, {8'h0, expb()});
    chk({31'h0, fault_lamp}, {31'h0, ctrl_m[7] | err_m[4] | err_m[1] | err_m[0]});
    chk({31'h0, error_log_enable}, {31'h0, ctrl_m[6:5] != 2'h2});
  endtask : query_chk

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    sw_pins = '0;
    events  = '0;
    ctrl_m  = 10'h000;
    sw_m    = 4'h0;
    err_m   = 5'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, DGSB_OFF_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, DGSB_OFF_STAT, 32'h0);
    chk(r, {8'h0, expb()});
    query_chk();
    // Unmapped address is refused, status word is read-only
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, DGSB_OFF_STAT, 32'hFFFFFFFF);
    apb(1'b0, DGSB_OFF_STAT, 32'h0);
    chk(r, {8'h0, expb()});
    for (int i = 0; i < 10; i++) begin
      ctrl_m = 10'h001 << i;
      apb(1'b1, DGSB_OFF_CTRL, {22'h0, ctrl_m});
      apb(1'b0, DGSB_OFF_CTRL, 32'h0);
      chk(r, {22'h0, ctrl_m});
      query_chk();
    end
    // Every log disable code, drive online
    for (int i = 0; i < 4; i++) begin
      ctrl_m = 10'h001 | (10'(i) << 5);
      apb(1'b1, DGSB_OFF_CTRL, {22'h0, ctrl_m});
      query_chk();
    end
    ctrl_m = 10'h001;
    apb(1'b1, DGSB_OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      sw_m = 4'h1 << i;
      sw_pins <= dgsb_sw_t'(sw_m);
      repeat (4) @(posedge pclk);
      query_chk();
    end
    // Each error source, with and without write protect
    for (int k = 0; k < 2; k++) begin
      sw_m = 4'(k);
      sw_pins <= dgsb_sw_t'(sw_m);
      repeat (4) @(posedge pclk);
      for (int i = 0; i < 7; i++) begin
        events <= dgsb_evt_t'(7'h01 << i);
        @(posedge pclk);
        events <= '0;
        err_m = evt_err(i, sw_m[0]);
        repeat (3) @(posedge pclk);
        apb(1'b0, DGSB_OFF_ERR, 32'h0);
        chk(r, {24'h0, err_m, 3'h0});
        query_chk();
        apb(1'b1, DGSB_OFF_ERR, 32'hF8);
        err_m = 5'h00;
        repeat (2) @(posedge pclk);
        query_chk();
      end
    end
    conclude();
  end
endmodule : dgsb_status_bytes_tb

`default_nettype wire
